// file: src/csfr_core.sv
/*
 * processor status register: alu flags, reset-cause bits, bank selects.
 * assumes instructions arrive one per cycle on the core clock, and the
 * master clear pin is asynchronous and active low.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - any instruction may write the status register
// - flag-affecting ops override only the written zero/dc/carry bits they own; clear also keeps dc/carry
// - time-out and power-down bits ignore writes
// - clear gives 000u u1uu
// - bit ops, swap, move leave flags
// - subtract carries mean no borrow
// - subtract adds two's complement of operand
// - digit carry from bit three carry
// - carry from most significant bit carry
// - rotates load carry with shifted-out bit
// - time-out set by power-up, clear, sleep
// - bank bit selects 128-byte direct bank
// - master clear keeps reset-cause bits
module csfr_core (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic op_valid,
	input wire csfr_pkg::csfr_op_t op_code,
	input wire logic [7:0] op_a,
	input wire logic [7:0] op_b,
	input wire logic [2:0] op_bit,
	input wire logic op_dest_status,
	output logic [7:0] op_result,
	output logic op_result_valid,
	input wire logic wdt_timeout,
	input wire logic master_clear_reset_n,
	input wire logic [6:0] direct_addr,
	output logic [7:0] data_addr,
	output logic [7:0] status_value,
	output logic indirect_bank_select,
	output logic bank_select_high,
	output logic bank_select_low,
	output logic timeout_flag_n,
	output logic powerdown_flag_n,
	output logic digit_carry_flag,
	output logic carry_flag,
	output logic zero_flag
);
	import csfr_pkg::*;
	csfr_alu_if aif ();
	logic [7:0] st_r;
	logic [7:0] st_nxt;
	logic [7:0] view;
	logic [7:0] wmask;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] res_r;
	logic [7:0] res_nxt;
	logic resv_r;
	logic resv_nxt;
	logic master_clear_reset_s1_r;
	logic master_clear_reset_s1_nxt;
	logic master_clear_reset_s2_r;
	logic master_clear_reset_s2_nxt;
	logic master_clear_reset_active;
	logic addr_hit;
	logic op_go;
	logic to_n;
	logic pd_n;
	// =====================================================================
	// master clear synchroniser
	always_comb begin
		master_clear_reset_s1_nxt = master_clear_reset_n;
		master_clear_reset_s2_nxt = master_clear_reset_s1_r;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			master_clear_reset_s1_r <= 1'b1;
			master_clear_reset_s2_r <= 1'b1;
		end else if (clk_en) begin
			master_clear_reset_s1_r <= master_clear_reset_s1_nxt;
			master_clear_reset_s2_r <= master_clear_reset_s2_nxt;
		end
	end
	assign master_clear_reset_active = !master_clear_reset_s2_r;
	assign addr_hit = (reg_addr == STATUS_ADDR_LO) || (reg_addr == STATUS_ADDR_HI);
	assign op_go = op_valid && !master_clear_reset_active;
	// =====================================================================
	// alu and reset-cause logic
	assign aif.op = op_code;
	assign aif.opa = op_a;
	assign aif.opb = op_b;
	assign aif.bit_sel = op_bit;
	assign aif.carry_in = view[C_BIT];
	csfr_alu u_alu (
		.bus(aif.alu)
	);
	csfr_rstcause u_cause (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.watchdog_clear_insn_evt(op_go && (op_code == OP_WATCHDOG_CLEAR_INSN)),
		.sleep_evt(op_go && (op_code == OP_SLEEP)),
		.wdt_timeout_evt(wdt_timeout),
		.timeout_flag_n(to_n),
		.powerdown_flag_n(pd_n)
	);
	// cause bits live only in the cause block, never in the written byte
	assign view = (st_r & ~MASK_CAUSE) | ({3'h0, to_n, pd_n, 3'h0} & MASK_CAUSE);
	// =====================================================================
	// status update
	always_comb begin
		st_nxt = st_r;
		wmask = MASK_WRITABLE & ~aif.flag_mask;
		if (op_code == OP_CLEAR_FILE_INSN) begin
			wmask = wmask & ~(MASK_DC | MASK_C);
		end
		if (master_clear_reset_active) begin
			st_nxt = st_r & ~MASK_TOP;
		end else if (op_valid) begin
			st_nxt = (st_r & ~aif.flag_mask) | (aif.flags & aif.flag_mask);
			if (op_dest_status) begin
				st_nxt = (st_nxt & ~wmask) | (aif.result & wmask);
			end
		end else if (reg_wr && addr_hit) begin
			st_nxt = (st_r & ~MASK_WRITABLE) | (reg_wdata & MASK_WRITABLE);
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= STATUS_RESET;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end
	// =====================================================================
	// read port and result
	always_comb begin
		rdata_nxt = (reg_rd && addr_hit) ? view : READ_IDLE;
		res_nxt = op_go ? aif.result : res_r;
		resv_nxt = op_go;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= READ_IDLE;
			res_r <= 8'h00;
			resv_r <= 1'b0;
		end else if (clk_en) begin
			rdata_r <= rdata_nxt;
			res_r <= res_nxt;
			resv_r <= resv_nxt;
		end
	end
	assign reg_rdata = rdata_r;
	assign op_result = res_r;
	assign op_result_valid = resv_r;
	assign data_addr = {view[RP0_BIT], direct_addr};
	assign status_value = view;
	assign indirect_bank_select = view[IRP_BIT];
	assign bank_select_high = view[RP1_BIT];
	assign bank_select_low = view[RP0_BIT];
	assign timeout_flag_n = view[TO_BIT];
	assign powerdown_flag_n = view[PD_BIT];
	assign zero_flag = view[Z_BIT];
	assign digit_carry_flag = view[DC_BIT];
	assign carry_flag = view[C_BIT];
	// =====================================================================
	// checks
	sequence s_op(csfr_op_t k);
		clk_en && op_valid && !master_clear_reset_active && (op_code == k);
	endsequence
	sequence s_quiet_op;
		clk_en && op_valid && !master_clear_reset_active && !op_dest_status &&
			(op_code inside {OP_BCF, OP_BSF, OP_SWAP, OP_MOVE_W_TO_FILE_INSN});
	endsequence
	a_bus_write_taken: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_wr && addr_hit && !op_valid && !master_clear_reset_active
		|=> view[7:5] == $past(reg_wdata[7:5]) && view[2:0] == $past(reg_wdata[2:0]))
		else $error("status write not taken");
	a_flag_write_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_ADD) ##0 op_dest_status
		|=> view[C_BIT] == ($past({1'b0, op_a} + {1'b0, op_b}) > 9'h0ff))
		else $error("flag write not replaced by result carry");
	a_cause_write_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_wr && addr_hit && !op_valid && !wdt_timeout
		|=> view[4:3] == $past(view[4:3]))
		else $error("cause bits changed by write");
	a_clear_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_CLEAR_FILE_INSN) ##0 op_dest_status
		|=> view[7:5] == 3'h0 && view[Z_BIT] && view[1:0] == $past(view[1:0]))
		else $error("clear of status gave wrong value");
	a_quiet_ops_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_quiet_op |=> view[2:0] == $past(view[2:0]))
		else $error("quiet op changed a flag");
	a_sub_borrow_sense: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_SUB) ##0 !op_dest_status
		|=> view[C_BIT] == ($past(op_a) >= $past(op_b)) &&
			view[DC_BIT] == ($past(op_a[3:0]) >= $past(op_b[3:0])))
		else $error("subtract borrow polarity wrong");
	a_add_digit_carry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_ADD) ##0 !op_dest_status
		|=> view[DC_BIT] == ($past({1'b0, op_a[3:0]} + {1'b0, op_b[3:0]}) > 5'h0f))
		else $error("digit carry wrong");
	a_rotate_carry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_op(OP_RRF) or s_op(OP_RLF)) ##0 !op_dest_status
		|=> view[C_BIT] == (($past(op_code) == OP_RRF) ? $past(op_a[0]) : $past(op_a[7])))
		else $error("rotate carry wrong");
	a_bank_address: assert property (@(posedge ref_clk) disable iff (!rst_n)
		data_addr[7] == bank_select_low && data_addr[6:0] == direct_addr)
		else $error("bank address wrong");
	a_master_clear_reset_keeps_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && master_clear_reset_active && !wdt_timeout
		|=> view[4:3] == $past(view[4:3]) && view[7:5] == 3'h0)
		else $error("master clear disturbed cause bits");
	a_zero_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_AND) ##0 !op_dest_status
		|=> view[Z_BIT] == ($past(op_a & op_b) == 8'h00))
		else $error("zero flag wrong");
	a_read_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_rd && addr_hit && !reg_wr ##1 clk_en && !reg_rd
		|-> reg_rdata == $past(view) ##1 reg_rdata == READ_IDLE || !clk_en)
		else $error("read data not one cycle");
	// =====================================================================
	// further checks
	sequence s_dest_op(csfr_op_t k);
		s_op(k) ##0 op_dest_status;
	endsequence
	sequence s_quiet_dest;
		clk_en && op_valid && !master_clear_reset_active && op_dest_status &&
			(op_code inside {OP_BCF, OP_BSF, OP_SWAP, OP_MOVE_W_TO_FILE_INSN});
	endsequence
	a_add_carry_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_ADD) ##0 !op_dest_status
		|=> carry_flag == ($past({1'b0, op_a} + {1'b0, op_b}) > 9'h0ff))
		else $error("add carry wrong");
	a_sub_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_SUB) |=> op_result == $past(op_a - op_b))
		else $error("subtract result wrong");
	a_sub_dest_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_dest_op(OP_SUB) |=> carry_flag == ($past(op_a) >= $past(op_b)))
		else $error("subtract flag write not replaced");
	a_rrf_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_RRF) |=> op_result == {$past(carry_flag), $past(op_a[7:1])})
		else $error("rotate right result wrong");
	a_quiet_dest_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_quiet_dest |=> view[7:5] == $past(aif.result[7:5]) && view[2:0] == $past(aif.result[2:0]))
		else $error("quiet op write to status wrong");
	a_zero_ior: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_IOR) ##0 !op_dest_status |=> zero_flag == ($past(op_a | op_b) == 8'h00))
		else $error("zero flag wrong after or");
	a_zero_xor: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_XOR) ##0 !op_dest_status |=> zero_flag == ($past(op_a ^ op_b) == 8'h00))
		else $error("zero flag wrong after xor");
	a_zero_comf: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_COMF) ##0 !op_dest_status |=> zero_flag == ($past(op_a) == 8'hff))
		else $error("zero flag wrong after complement");
	a_zero_clear_file_insn: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_CLEAR_FILE_INSN) |=> zero_flag)
		else $error("zero flag not set by clear");
	a_sleep_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_SLEEP) ##0 !wdt_timeout |=> !powerdown_flag_n && timeout_flag_n)
		else $error("sleep cause pins wrong");
	a_watchdog_clear_insn_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_op(OP_WATCHDOG_CLEAR_INSN) ##0 !wdt_timeout |=> timeout_flag_n && powerdown_flag_n)
		else $error("watchdog clear cause pins wrong");
	a_wdt_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wdt_timeout |=> !timeout_flag_n)
		else $error("time-out pin not cleared");
	a_master_clear_reset_blocks_ops: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && master_clear_reset_active && op_valid |=> !op_result_valid)
		else $error("instruction ran during master clear");
	a_master_clear_reset_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && master_clear_reset_active && reg_wr && !op_valid |=> view[2:0] == $past(view[2:0]))
		else $error("write taken during master clear");
	a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && reg_rd && !addr_hit |=> reg_rdata == READ_IDLE)
		else $error("unmapped read not idle");
	a_result_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && op_go |=> op_result_valid)
		else $error("result valid missing");
	a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> view == $past(view) && op_result == $past(op_result) && reg_rdata == $past(reg_rdata))
		else $error("state changed while clock enable low");
endmodule : csfr_core
`default_nettype wire

// file: src/csfr_pkg.sv
/*
 * constants, field positions and op codes of the processor status register.
 * assumes an 8-bit core datapath on a single core clock.
 */
package csfr_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned BIT_SEL_W = 3;
	localparam int unsigned DIRECT_W = 7;
	localparam int unsigned BANK_BYTES = 128;
	// =====================================================================
	// register decode
	localparam logic [7:0] STATUS_ADDR_LO = 8'h03;
	localparam logic [7:0] STATUS_ADDR_HI = 8'h83;
	localparam logic [7:0] READ_IDLE = 8'h00;
	// =====================================================================
	// field positions
	localparam int unsigned C_BIT = 0;
	localparam int unsigned DC_BIT = 1;
	localparam int unsigned Z_BIT = 2;
	localparam int unsigned PD_BIT = 3;
	localparam int unsigned TO_BIT = 4;
	localparam int unsigned RP0_BIT = 5;
	localparam int unsigned RP1_BIT = 6;
	localparam int unsigned IRP_BIT = 7;
	// =====================================================================
	// masks and reset values
	localparam logic [7:0] MASK_C = 8'h01;
	localparam logic [7:0] MASK_DC = 8'h02;
	localparam logic [7:0] MASK_Z = 8'h04;
	localparam logic [7:0] MASK_FLAGS = 8'h07;
	localparam logic [7:0] MASK_CAUSE = 8'h18;
	localparam logic [7:0] MASK_TOP = 8'he0;
	localparam logic [7:0] MASK_WRITABLE = 8'he7;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic TO_RESET = 1'b1;
	localparam logic PD_RESET = 1'b1;
	// =====================================================================
	// one-hot instruction codes
	typedef enum logic [15:0] {
		OP_NONE = 16'h0001,
		OP_ADD = 16'h0002,
		OP_SUB = 16'h0004,
		OP_AND = 16'h0008,
		OP_IOR = 16'h0010,
		OP_XOR = 16'h0020,
		OP_RRF = 16'h0040,
		OP_RLF = 16'h0080,
		OP_CLEAR_FILE_INSN = 16'h0100,
		OP_SWAP = 16'h0200,
		OP_MOVE_W_TO_FILE_INSN = 16'h0400,
		OP_BCF = 16'h0800,
		OP_BSF = 16'h1000,
		OP_COMF = 16'h2000,
		OP_WATCHDOG_CLEAR_INSN = 16'h4000,
		OP_SLEEP = 16'h8000
	} csfr_op_t;
endpackage : csfr_pkg

// file: src/csfr_alu_if.sv
/*
 * interface between the status core and its flag-producing alu.
 * assumes both ends are on the core clock; the alu end is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface csfr_alu_if;
	import csfr_pkg::*;
	csfr_op_t op;
	logic [7:0] opa;
	logic [7:0] opb;
	logic [2:0] bit_sel;
	logic carry_in;
	logic [7:0] result;
	logic [7:0] flags;
	logic [7:0] flag_mask;
	modport alu (input op, input opa, input opb, input bit_sel, input carry_in,
		output result, output flags, output flag_mask);
	modport core (output op, output opa, output opb, output bit_sel, output carry_in,
		input result, input flags, input flag_mask);
endinterface : csfr_alu_if
`default_nettype wire

// file: src/csfr_alu.sv
/*
 * combinational alu: result, new zero/digit carry/carry and which of them the op owns.
 * assumes opa is the file operand and opb the working register.
 */
`timescale 1ns/1ps
`default_nettype none
module csfr_alu (
	csfr_alu_if.alu bus
);
	import csfr_pkg::*;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] bmask;
	logic [7:0] res;
	logic c_out;
	logic dc_out;
	logic [7:0] fmask;
	// =====================================================================
	// operation decode
	always_comb begin
		bmask = 8'h01 << bus.bit_sel;
		sum = 9'h000;
		nib = 5'h00;
		res = bus.opa;
		c_out = bus.carry_in;
		dc_out = 1'b0;
		fmask = 8'h00;
		case (bus.op)
			OP_ADD: begin
				sum = {1'b0, bus.opa} + {1'b0, bus.opb};
				nib = {1'b0, bus.opa[3:0]} + {1'b0, bus.opb[3:0]};
				res = sum[7:0];
				c_out = sum[8];
				dc_out = nib[4];
				fmask = MASK_FLAGS;
			end
			OP_SUB: begin
				// add two's complement, carry 1 means no borrow
				sum = {1'b0, bus.opa} + {1'b0, ~bus.opb} + 9'h001;
				nib = {1'b0, bus.opa[3:0]} + {1'b0, ~bus.opb[3:0]} + 5'h01;
				res = sum[7:0];
				c_out = sum[8];
				dc_out = nib[4];
				fmask = MASK_FLAGS;
			end
			OP_AND: begin
				res = bus.opa & bus.opb;
				fmask = MASK_Z;
			end
			OP_IOR: begin
				res = bus.opa | bus.opb;
				fmask = MASK_Z;
			end
			OP_XOR: begin
				res = bus.opa ^ bus.opb;
				fmask = MASK_Z;
			end
			OP_COMF: begin
				res = ~bus.opa;
				fmask = MASK_Z;
			end
			OP_RRF: begin
				res = {bus.carry_in, bus.opa[7:1]};
				c_out = bus.opa[0];
				fmask = MASK_C;
			end
			OP_RLF: begin
				res = {bus.opa[6:0], bus.carry_in};
				c_out = bus.opa[7];
				fmask = MASK_C;
			end
			OP_CLEAR_FILE_INSN: begin
				res = 8'h00;
				fmask = MASK_Z;
			end
			OP_SWAP: res = {bus.opa[3:0], bus.opa[7:4]};
			OP_MOVE_W_TO_FILE_INSN: res = bus.opb;
			OP_BCF: res = bus.opa & ~bmask;
			OP_BSF: res = bus.opa | bmask;
			default: res = bus.opa;
		endcase
	end
	assign bus.result = res;
	// zero flag follows the result whenever the op owns it
	assign bus.flags = {5'h00, (res == 8'h00), dc_out, c_out};
	assign bus.flag_mask = fmask;
endmodule : csfr_alu
`default_nettype wire

// file: src/csfr_rstcause.sv
/*
 * reset-cause bits: time-out and power-down, both active low.
 * assumes event inputs are one-cycle pulses on the core clock; rst_n is power-up.
 */
`timescale 1ns/1ps
`default_nettype none
module csfr_rstcause (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic watchdog_clear_insn_evt,
	input wire logic sleep_evt,
	input wire logic wdt_timeout_evt,
	output logic timeout_flag_n,
	output logic powerdown_flag_n
);
	import csfr_pkg::*;
	logic to_r;
	logic to_nxt;
	logic pd_r;
	logic pd_nxt;
	// =====================================================================
	// cause update, time-out wins over a same-cycle clear
	always_comb begin
		to_nxt = to_r;
		pd_nxt = pd_r;
		if (watchdog_clear_insn_evt) begin
			to_nxt = 1'b1;
			pd_nxt = 1'b1;
		end
		if (sleep_evt) begin
			to_nxt = 1'b1;
			pd_nxt = 1'b0;
		end
		if (wdt_timeout_evt) begin
			to_nxt = 1'b0;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			to_r <= TO_RESET;
			pd_r <= PD_RESET;
		end else if (clk_en) begin
			to_r <= to_nxt;
			pd_r <= pd_nxt;
		end
	end
	assign timeout_flag_n = to_r;
	assign powerdown_flag_n = pd_r;
	// =====================================================================
	// checks
	a_timeout_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wdt_timeout_evt |=> !timeout_flag_n)
		else $error("time-out bit not cleared by watchdog time-out");
	a_sleep_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && sleep_evt && !wdt_timeout_evt |=> !powerdown_flag_n && timeout_flag_n)
		else $error("sleep did not set cause bits");
	a_watchdog_clear_insn_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && watchdog_clear_insn_evt && !sleep_evt && !wdt_timeout_evt |=> powerdown_flag_n && timeout_flag_n)
		else $error("watchdog clear did not set cause bits");
endmodule : csfr_rstcause
`default_nettype wire

// file: test/cpu_status_flags_register_test.sv
/*
 * self-checking bench of the processor status register core.
 * assumes csfr_pkg and csfr_core are compiled first; clk_en is held high except for one frozen cycle at the end.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flags_register_test;
	import csfr_pkg::*;
	// =====================================================================
	// signals
	logic ref_clk, rst_n, clk_en, reg_wr, reg_rd, op_valid, op_dest_status, wdt_timeout, master_clear_reset_n;
	logic [7:0] reg_addr, reg_wdata, op_a, op_b, reg_rdata, op_result, data_addr, status_value;
	logic [2:0] op_bit;
	logic [6:0] direct_addr;
	csfr_op_t op_code;
	logic op_result_valid, irp_o, rp1_o, rp0_o, to_o, pd_o, z_o, dcf_o, c_o;
	logic [7:0] exp_s, r;
	int n_mismatch, checked, cyc;
	localparam csfr_op_t TBL [13] = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_RRF, OP_RLF,
		OP_CLEAR_FILE_INSN, OP_SWAP, OP_MOVE_W_TO_FILE_INSN, OP_BCF, OP_BSF, OP_COMF};
	csfr_core csfr_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
		.op_code(op_code), .op_a(op_a), .op_b(op_b), .op_bit(op_bit), .op_dest_status(op_dest_status),
		.op_result(op_result), .op_result_valid(op_result_valid), .wdt_timeout(wdt_timeout),
		.master_clear_reset_n(master_clear_reset_n), .direct_addr(direct_addr), .data_addr(data_addr),
		.status_value(status_value), .indirect_bank_select(irp_o), .bank_select_high(rp1_o),
		.bank_select_low(rp0_o), .timeout_flag_n(to_o), .powerdown_flag_n(pd_o),
		.digit_carry_flag(dcf_o), .carry_flag(c_o), .zero_flag(z_o));
	// =====================================================================
	// expectation functions
	function automatic logic [7:0] f_res(csfr_op_t op, logic [7:0] a, logic [7:0] b, logic [2:0] n, logic ci);
		case (op)
			OP_ADD: f_res = a + b;
			OP_SUB: f_res = a + ~b + 8'h01;
			OP_AND: f_res = a & b;
			OP_IOR: f_res = a | b;
			OP_XOR: f_res = a ^ b;
			OP_COMF: f_res = ~a;
			OP_RRF: f_res = {ci, a[7:1]};
			OP_RLF: f_res = {a[6:0], ci};
			OP_CLEAR_FILE_INSN: f_res = 8'h00;
			OP_SWAP: f_res = {a[3:0], a[7:4]};
			OP_MOVE_W_TO_FILE_INSN: f_res = b;
			OP_BCF: f_res = a & ~(8'h01 << n);
			OP_BSF: f_res = a | (8'h01 << n);
			default: f_res = a;
		endcase
	endfunction : f_res
	function automatic logic [7:0] f_st(csfr_op_t op, logic [7:0] a, logic [7:0] b, logic [2:0] n,
		logic [7:0] s, logic dest);
		logic [7:0] rr, m, t, f;
		logic [8:0] w;
		logic [4:0] h;
		logic cf;
		rr = f_res(op, a, b, n, s[0]);
		m = (op == OP_ADD || op == OP_SUB) ? MASK_FLAGS :
			(op inside {OP_AND, OP_IOR, OP_XOR, OP_COMF, OP_CLEAR_FILE_INSN}) ? MASK_Z :
			(op inside {OP_RRF, OP_RLF}) ? MASK_C : 8'h00;
		t = s;
		if (dest) t = (s & MASK_CAUSE) | (rr & MASK_WRITABLE);
		if (dest && op == OP_CLEAR_FILE_INSN) t = (t & 8'hfc) | (s & 8'h03);
		w = (op == OP_SUB) ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
		h = (op == OP_SUB) ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01 : {1'b0, a[3:0]} + {1'b0, b[3:0]};
		cf = (op == OP_RRF) ? a[0] : (op == OP_RLF) ? a[7] : w[8];
		f = {5'h00, rr == 8'h00, h[4], cf};
		t = (t & ~m) | (f & m);
		if (op == OP_SLEEP) t[4:3] = 2'b10;
		if (op == OP_WATCHDOG_CLEAR_INSN) t[4:3] = 2'b11;
		return t;
	endfunction : f_st
	// =====================================================================
	// tasks
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic chk_st();
		chk("status", status_value, exp_s);
		chk("flag pins", {irp_o, rp1_o, rp0_o, to_o, pd_o, z_o, dcf_o, c_o}, exp_s);
		chk("data addr", data_addr, {exp_s[5], direct_addr});
	endtask : chk_st
	task automatic do_op(csfr_op_t op, logic [7:0] a, logic [7:0] b, logic [2:0] n, logic dest);
		logic [7:0] aa;
		aa = dest ? exp_s : a;
		r = f_res(op, aa, b, n, exp_s[0]);
		exp_s = f_st(op, aa, b, n, exp_s, dest);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= op;
		op_a <= aa;
		op_b <= b;
		op_bit <= n;
		op_dest_status <= dest;
		direct_addr <= 7'($urandom);
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		chk_st();
		chk("result valid", {7'h00, op_result_valid}, 8'h01);
		if (!(op inside {OP_NONE, OP_SLEEP, OP_WATCHDOG_CLEAR_INSN})) chk("result", op_result, r);
	endtask : do_op
	task automatic bus_wr(logic [7:0] ad, logic [7:0] d, logic hit);
		if (hit) exp_s = (exp_s & MASK_CAUSE) | (d & MASK_WRITABLE);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
		chk_st();
	endtask : bus_wr
	task automatic bus_rd(logic [7:0] ad, logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk("read data", reg_rdata, exp);
	endtask : bus_rd
	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	// =====================================================================
	// clock and timeout
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// =====================================================================
	// main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, op_valid, op_dest_status, wdt_timeout} = '0;
		{clk_en, master_clear_reset_n} = 2'b11;
		{reg_addr, reg_wdata, op_a, op_b, op_bit, direct_addr} = '0;
		op_code = OP_NONE;
		n_mismatch = 0;
		checked = 0;
		cyc = 0;
		void'($urandom(32'hf41800dc));
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		exp_s = STATUS_RESET;
		chk_st();
		bus_wr(STATUS_ADDR_LO, 8'hff, 1'b1);
		bus_rd(STATUS_ADDR_HI, exp_s);
		bus_wr(STATUS_ADDR_HI, 8'h00, 1'b1);
		bus_wr(8'h04, 8'hff, 1'b0);
		bus_rd(8'h04, READ_IDLE);
		do_op(OP_ADD, 8'hf8, 8'h08, 3'h0, 1'b0);
		do_op(OP_SUB, 8'h10, 8'h00, 3'h0, 1'b0);
		do_op(OP_SUB, 8'h10, 8'h11, 3'h0, 1'b0);
		do_op(OP_SUB, 8'h5a, 8'h5a, 3'h0, 1'b0);
		bus_wr(STATUS_ADDR_LO, 8'he0, 1'b1);
		do_op(OP_CLEAR_FILE_INSN, 8'h00, 8'h00, 3'h0, 1'b1);
		do_op(OP_ADD, 8'h00, 8'hff, 3'h0, 1'b1);
		foreach (TBL[i]) do_op(TBL[i], 8'($urandom), 8'($urandom), 3'($urandom), 1'b1);
		for (int i = 0; i < 60; i++) begin
			do_op(TBL[$urandom % 13], 8'($urandom), 8'($urandom), 3'($urandom), ($urandom % 4) == 0);
		end
		do_op(OP_SLEEP, 8'h00, 8'h00, 3'h0, 1'b0);
		do_op(OP_WATCHDOG_CLEAR_INSN, 8'h00, 8'h00, 3'h0, 1'b0);
		@(posedge ref_clk);
		wdt_timeout <= 1'b1;
		@(posedge ref_clk);
		wdt_timeout <= 1'b0;
		#1;
		exp_s[4] = 1'b0;
		chk_st();
		do_op(OP_SLEEP, 8'h00, 8'h00, 3'h0, 1'b0);
		bus_wr(STATUS_ADDR_LO, 8'he7, 1'b1);
		master_clear_reset_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		#1;
		exp_s = exp_s & 8'h1f;
		chk_st();
		bus_wr(STATUS_ADDR_LO, 8'he0, 1'b0);
		master_clear_reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		do_op(OP_BSF, exp_s, 8'h00, 3'h5, 1'b1);
		do_op(OP_WATCHDOG_CLEAR_INSN, 8'h00, 8'h00, 3'h0, 1'b0);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		op_valid <= 1'b1;
		op_code <= OP_CLEAR_FILE_INSN;
		op_dest_status <= 1'b1;
		@(posedge ref_clk);
		clk_en <= 1'b1;
		op_valid <= 1'b0;
		#1;
		chk_st();
		chk("frozen valid", {7'h00, op_result_valid}, 8'h00);
		stop_test();
	end
endmodule : cpu_status_flags_register_test
`default_nettype wire
